/* bench/ifd_decoder_bench.sv */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Self-checking bench of the decoder fed by the memory model.
module ifd_decoder_bench;
  logic              sys_clk, sys_rst, branch_taken, cycle_end;
  logic              word_taken, dispatch, flushed;
  logic [15:0]       instr_word;
  logic [1:0]        phase;
  ifd_pkg::ifd_dec_t dec;
  int                fail_count, cmp_count, clk_n, last_n;

  ifd_decoder #(.PHASES(4)) i_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .INSTR_WORD(instr_word), .BRANCH_TAKEN(branch_taken), .PHASE(phase),
    .CYCLE_END(cycle_end), .WORD_TAKEN(word_taken), .DISPATCH(dispatch),
    .FLUSHED(flushed), .DECODED(dec));
  ifd_prog_mem i_mem (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .word_taken(word_taken), .instr_word(instr_word));

  // Clock and a running edge count for slot spacing.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) clk_n <= clk_n + 1;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits for the next issued op, checks its spacing, may signal a jump.
  task automatic get_op(input logic br, input int gap);
    int n;
    n = 0;
    @(negedge sys_clk);
    branch_taken = 1'b0;
    while (dispatch !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 20) begin
        fail_count++;
        wrap_up();
      end
    end
    if (gap > 0) check("gap", 16'(clk_n - last_n), 16'(gap));
    last_n = clk_n;
    if (br) begin
      repeat (3) @(negedge sys_clk);
      branch_taken = 1'b1;
    end
  endtask

  task automatic t_byte();
    get_op(1'b0, 0);
    check("opcode", 16'(dec.opcode), 16'h0027);
    check("reg", 16'(dec.reg_addr), 16'h00a5);
    check("sel", 16'({dec.result_to_file, dec.result_to_working,
      dec.access_ram, dec.bank_from_select}), 16'h0009);
    get_op(1'b0, 4);
    check("sel", 16'({dec.result_to_file, dec.result_to_working,
      dec.access_ram, dec.bank_from_select}), 16'h0006);
    $display("byte test done");
  endtask

  task automatic t_bit();
    logic [2:0] pos [3] = '{3'h0, 3'h5, 3'h7};
    logic       bnk [3] = '{1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      get_op(1'b0, 4);
      check("cls", 16'(dec.cls), 16'(ifd_pkg::CLS_BIT));
      check("pos", 16'(dec.bit_pos), 16'(pos[i]));
      check("mask", 16'(dec.bit_mask), 16'(8'h01 << pos[i]));
      check("bank", 16'(dec.bank_from_select), 16'(bnk[i]));
    end
    $display("bit test done");
  endtask

  task automatic t_lit_table();
    get_op(1'b0, 4);
    check("lit", 16'(dec.literal_value), 16'h005a);
    for (int m = 0; m < 4; m++) begin
      get_op(1'b0, 4);
      check("cls", 16'(dec.cls), 16'(ifd_pkg::CLS_CONTROL));
      check("tbl", 16'(dec.table_mode), 16'(m));
    end
    $display("literal and table test done");
  endtask

  task automatic t_two_word();
    get_op(1'b0, 8);
    check("two", 16'(dec.two_word), 16'h0001);
    check("ptr", 16'(dec.pointer_sel), 16'h0002);
    check("lit", 16'(dec.literal_value), 16'h00c7);
    get_op(1'b0, 8);
    check("quick", 16'(dec.quick_return), 16'h0001);
    check("off", 16'(dec.target_offset), 16'h0005);
    check("ext", 16'(dec.ext_operand), 16'h0abc);
    get_op(1'b0, 8);
    check("ext", 16'(dec.ext_operand), 16'h0345);
    get_op(1'b0, 4);
    check("lone", 16'({dec.cls, dec.two_word}), 16'h0008);
    $display("double word test done");
  endtask

  task automatic t_branch();
    get_op(1'b1, 4);
    get_op(1'b0, 4);
    check("flush", 16'({flushed, dec.cls}), 16'h000c);
    get_op(1'b0, 4);
    check("after", 16'({flushed, dec.literal_value}), 16'h0033);
    get_op(1'b0, 4);
    check("jump cls", 16'(dec.cls), 16'(ifd_pkg::CLS_CONTROL));
    check("jump off", 16'(dec.target_offset), 16'h03a5);
    get_op(1'b1, 8);
    check("two br", 16'(dec.ext_operand), 16'h00aa);
    get_op(1'b0, 4);
    check("flush two", 16'({flushed, dec.cls}), 16'h000c);
    get_op(1'b0, 4);
    check("after two", 16'({flushed, dec.literal_value}), 16'h0044);
    $display("branch test done");
  endtask

  // Reset, reset state, then every scenario in program order.
  initial begin
    sys_rst = 1'b1;
    branch_taken = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    last_n = 0;
    repeat (8) @(negedge sys_clk);
    check("rst", 16'({phase, dispatch, flushed}), 16'h0000);
    check("rst dec", 16'(dec.opcode), 16'h0000);
    sys_rst = 1'b0;
    t_byte();
    t_bit();
    t_lit_table();
    t_two_word();
    t_branch();
    wrap_up();
  end
endmodule
`default_nettype wire

/* bench/ifd_decoder_checker.sv */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Port level timing and field checks of the decoder.
module ifd_decoder_checker #(
  parameter int PHASES = 4
) (
  input wire logic              SYS_CLK,       // Core clock.
  input wire logic              SYS_RST,       // Sync reset.
  input wire logic [15:0]       INSTR_WORD,    // Fetched word.
  input wire logic              BRANCH_TAKEN,  // Last op jumped.
  input wire logic [1:0]        PHASE,         // Period index.
  input wire logic              CYCLE_END,     // Cycle boundary.
  input wire logic              WORD_TAKEN,    // Word consumed.
  input wire logic              DISPATCH,      // New op issued.
  input wire logic              FLUSHED,       // Slot is no-op.
  input wire ifd_pkg::ifd_dec_t DECODED        // Decoded op.
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  phase_count_a: assert property (PHASE != 2'h3 |=>
    PHASE == $past(PHASE) + 2'h1) else $error("phase did not step");
  cycle_wrap_a: assert property (PHASE == 2'h3 |=>
    PHASE == 2'h0 && CYCLE_END) else $error("cycle did not wrap");
  strobe_once_a: assert property (CYCLE_END |=> !CYCLE_END [*3])
    else $error("boundary strobe too close");
  strobe_pair_a: assert property (WORD_TAKEN == CYCLE_END &&
    (!DISPATCH || CYCLE_END)) else $error("strobes out of step");
  ext_join_a: assert property (CYCLE_END && !DISPATCH |->
    ##4 DISPATCH && DECODED.two_word) else $error("second word lost");
  flush_nop_a: assert property (PHASE == 2'h3 && BRANCH_TAKEN &&
    $past(DISPATCH, 3) |=> DISPATCH && FLUSHED &&
    DECODED.cls == ifd_pkg::CLS_NOP) else $error("no flush slot");
  hold_dec_a: assert property (!DISPATCH |-> $stable(DECODED))
    else $error("decoded op changed");
  bit_mask_a: assert property (DISPATCH &&
    DECODED.cls == ifd_pkg::CLS_BIT |->
    DECODED.bit_mask == (8'h01 << DECODED.bit_pos)) else $error("bad mask");
  byte_sel_a: assert property (DISPATCH &&
    DECODED.cls == ifd_pkg::CLS_BYTE |->
    DECODED.result_to_file != DECODED.result_to_working &&
    DECODED.access_ram != DECODED.bank_from_select) else $error("bad sel");
endmodule

bind ifd_decoder ifd_decoder_checker #(.PHASES(PHASES)) i_chk (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .INSTR_WORD(INSTR_WORD),
  .BRANCH_TAKEN(BRANCH_TAKEN), .PHASE(PHASE), .CYCLE_END(CYCLE_END),
  .WORD_TAKEN(WORD_TAKEN), .DISPATCH(DISPATCH), .FLUSHED(FLUSHED),
  .DECODED(DECODED));
`default_nettype wire

/* bench/ifd_prog_mem.sv */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Program memory model that hands one word per consumed slot.
module ifd_prog_mem (
  input  wire logic        sys_clk,     // Core clock.
  input  wire logic        sys_rst,     // Sync reset.
  input  wire logic        word_taken,  // Advance request.
  output logic [15:0]      instr_word   // Word at fetch address.
);
  logic [15:0] mem [32];
  logic [4:0]  addr_q;

  // Program image; second words start with four ones.
  initial begin
    foreach (mem[i]) mem[i] = 16'hf000;
    mem[0] = 16'h27a5; mem[1] = 16'h2c3c; mem[2] = 16'h7012;
    mem[3] = 16'h9b12; mem[4] = 16'hbe34; mem[5] = 16'h0e5a;
    for (int i = 0; i < 4; i++) mem[6+i] = 16'h0008 + 16'(i);
    mem[10] = 16'hee20; mem[11] = 16'hf0c7; mem[12] = 16'hed05;
    mem[13] = 16'hfabc; mem[14] = 16'hef12; mem[15] = 16'hf345;
    mem[16] = 16'hf123; mem[17] = 16'h0e11; mem[18] = 16'h2222;
    mem[19] = 16'h0e33;
    mem[20] = 16'hd3a5;
    mem[21] = 16'hee10;
    mem[22] = 16'hf0aa;
    mem[23] = 16'h2222;
    mem[24] = 16'h0e44;
  end

  // Fetch address moves only after the decoder consumed the word.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) addr_q <= 5'h00;
    else if (word_taken) addr_q <= addr_q + 5'h01;
  end

  assign instr_word = mem[addr_q];
endmodule
`default_nettype wire

/* design/ifd_decoder.sv */
// What this block does
// (RULE1) Most instructions are one 16-bit word; exactly three use two words.
// (RULE2) Split each word into an opcode and one or more operand fields.
// (RULE3) Byte class decodes register address, result target and memory bit.
// (RULE4) Result target zero writes working register; one writes file register.
// (RULE5) Bit class decodes register address, bit position and memory bit.
// (RULE6) Bit position selects the single bit modified or tested.
// (RULE7) Literal class decodes a literal, an indirect pointer select, or none.
// (RULE8) Control class decodes offset, quick return bit, table mode, or none.
// (RULE9) Second words start with four ones; executed alone they are no-ops.
// (RULE10) A plain single-word instruction takes one instruction cycle.
// (RULE11) Taken test or program counter change adds one no-op cycle.
// (RULE12) Double-word instructions take two instruction cycles.
// (RULE13) One instruction cycle is four consecutive clock periods.
// (RULE14) A taken two-word branch takes three instruction cycles in total.
// (RULE15) Memory bit zero means access RAM; one means bank from bank select.
// (RULE16) Bit position is three bits, addressing bits 0 to 7.
// (RULE17) Quick return bit one updates shadow registers; zero leaves them.
// (RULE18) Table mode: no change, post-increment, post-decrement, pre-increment.
// (RULE19) The second word is an operand extension, never dispatched alone; here a lone second word is dispatched as a no-op.
// (RULE20) On a taken branch the fetched next word is dropped for a no-op.
`timescale 1ns/10ps
`default_nettype none

module ifd_decoder #(
  parameter int PHASES = ifd_pkg::PHASES_DEF
) (
  input  wire logic                        SYS_CLK,         // Core clock.
  input  wire logic                        SYS_RST,         // Sync reset.
  input  wire logic [ifd_pkg::WORD_W-1:0]  INSTR_WORD,      // Fetched word.
  input  wire logic                        BRANCH_TAKEN,    // Last op jumped.
  output logic [1:0]                       PHASE,           // Period index.
  output logic                             CYCLE_END,       // Cycle boundary.
  output logic                             WORD_TAKEN,      // Word consumed.
  output logic                             DISPATCH,        // New op issued.
  output logic                             FLUSHED,         // Slot is no-op.
  output ifd_pkg::ifd_dec_t                DECODED          // Decoded op.
);

  // ============================================================
  // Elaboration check: the phase index is two bits wide.
  if (PHASES != ifd_pkg::PHASES_DEF) begin : g_phase_check
    $error("PHASES must be 4 for a two bit phase index.");
  end

  // ============================================================
  // Decode functions.

  // Builds the single-word view of a word, second words read as no-op.
  function automatic ifd_pkg::ifd_dec_t split_word(
    input logic [ifd_pkg::WORD_W-1:0] w
  );
    ifd_pkg::ifd_dec_t d;
    logic [3:0]        top;
    logic [3:0]        sub;
    d   = '0;
    top = w[ifd_pkg::TOP_HI:ifd_pkg::TOP_LO];
    sub = w[ifd_pkg::SUB_HI:ifd_pkg::SUB_LO];
    d.opcode = w[ifd_pkg::WORD_W-1:ifd_pkg::FILE_W];               // RULE2
    if (top == ifd_pkg::TOP_EXT) begin
      d.cls = ifd_pkg::CLS_NOP;                                    // RULE9
    end else if (top >= ifd_pkg::TOP_BIT_LO &&
                 top <= ifd_pkg::TOP_BIT_HI) begin
      d.cls        = ifd_pkg::CLS_BIT;                             // RULE5
      d.reg_addr   = w[ifd_pkg::FILE_W-1:0];
      d.bit_pos    = w[ifd_pkg::BIT_HI:ifd_pkg::BIT_LO];           // RULE16
      d.bit_mask   = ifd_pkg::FILE_W'(1) << d.bit_pos;             // RULE6
      d.access_ram = ~w[ifd_pkg::MEM_POS];                         // RULE15
    end else if (top == ifd_pkg::TOP_JUMP) begin
      d.cls           = ifd_pkg::CLS_CONTROL;                      // RULE8
      d.target_offset = w[ifd_pkg::OFFSET_W-1:0];
    end else if (top == ifd_pkg::TOP_LONG) begin
      if (sub == ifd_pkg::SUB_PTRLD) begin
        d.cls           = ifd_pkg::CLS_LITERAL;                    // RULE7
        d.pointer_sel   = w[ifd_pkg::PTR_HI:ifd_pkg::PTR_LO];
        d.literal_value = {4'h0, w[3:0]};
        d.two_word      = 1'b1;                                    // RULE1
      end else begin
        d.cls           = ifd_pkg::CLS_CONTROL;                    // RULE8
        d.target_offset = {3'h0, w[ifd_pkg::FILE_W-1:0]};
        if (w[ifd_pkg::CALL_HI:ifd_pkg::CALL_LO] == ifd_pkg::SUB_CALL) begin
          d.quick_return = w[ifd_pkg::QUICK_POS];                  // RULE17
          d.two_word     = 1'b1;                                   // RULE1
        end else if (sub == ifd_pkg::SUB_GOTO) begin
          d.two_word = 1'b1;                                       // RULE1
        end
      end
    end else if (top == ifd_pkg::TOP_MISC) begin
      if (sub != ifd_pkg::SUB_NONE) begin
        d.cls           = ifd_pkg::CLS_LITERAL;                    // RULE7
        d.literal_value = w[ifd_pkg::FILE_W-1:0];
      end else begin
        d.cls          = ifd_pkg::CLS_CONTROL;                     // RULE8
        d.table_mode   = ifd_pkg::ifd_tbl_t'(
                           w[ifd_pkg::MODE_HI:ifd_pkg::MODE_LO]);  // RULE18
        d.quick_return = w[ifd_pkg::MODE_LO];                      // RULE17
      end
    end else begin
      d.cls               = ifd_pkg::CLS_BYTE;                     // RULE3
      d.reg_addr          = w[ifd_pkg::FILE_W-1:0];
      d.result_to_file    = w[ifd_pkg::DEST_POS];                  // RULE4
      d.result_to_working = ~w[ifd_pkg::DEST_POS];                 // RULE4
      d.access_ram        = ~w[ifd_pkg::MEM_POS];                  // RULE15
    end
    d.bank_from_select = (d.cls == ifd_pkg::CLS_BYTE ||
                          d.cls == ifd_pkg::CLS_BIT) &&
                         w[ifd_pkg::MEM_POS];                      // RULE15
    return d;
  endfunction

  // Folds the second word into the held first word as its operand.
  function automatic ifd_pkg::ifd_dec_t join_ext(
    input ifd_pkg::ifd_dec_t          first,
    input logic [ifd_pkg::WORD_W-1:0] w
  );
    ifd_pkg::ifd_dec_t d;
    d             = first;
    d.ext_operand = w[ifd_pkg::EXT_W-1:0];                         // RULE19
    if (first.cls == ifd_pkg::CLS_LITERAL) begin
      d.literal_value = w[ifd_pkg::FILE_W-1:0];
    end
    return d;
  endfunction

  // ============================================================
  // State machine of the issue slot.
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_EXT = 2'b10
  } ifd_state_t;

  ifd_state_t        st_q;
  ifd_state_t        st_d;
  logic [1:0]        phase_q;
  logic [1:0]        phase_d;
  logic              end_q;
  logic              taken_q;
  logic              disp_q;
  logic              flush_q;
  ifd_pkg::ifd_dec_t first_q;
  ifd_pkg::ifd_dec_t dec_q;
  ifd_pkg::ifd_dec_t dec_d;

  // Boundary of the instruction cycle and the decoded views.
  wire logic              boundary = (phase_q == 2'(PHASES - 1));  // RULE13
  ifd_pkg::ifd_dec_t      word_view;
  ifd_pkg::ifd_dec_t      ext_view;
  assign word_view = split_word(INSTR_WORD);
  assign ext_view  = join_ext(first_q, INSTR_WORD);

  // A taken branch drops the word just fetched and issues a no-op.
  wire logic do_flush = boundary && st_q == ST_RUN && BRANCH_TAKEN; // RULE20
  wire logic start_ext = boundary && st_q == ST_RUN && !BRANCH_TAKEN &&
                         word_view.two_word;                       // RULE12
  wire logic issue = boundary && !start_ext;                       // RULE10

  // Next phase, state and decoded output.
  always_comb begin
    phase_d = boundary ? ifd_pkg::PHASE_RST : phase_q + 2'h1;      // RULE13
    st_d    = st_q;
    dec_d   = dec_q;
    case (st_q)
      ST_RUN: begin
        if (do_flush) begin
          dec_d     = '0;                                          // RULE11
          dec_d.cls = ifd_pkg::CLS_NOP;                            // RULE11
        end else if (start_ext) begin
          st_d = ST_EXT;                                           // RULE12
        end else if (boundary) begin
          dec_d = word_view;                                       // RULE10
        end
      end
      ST_EXT: begin
        if (boundary) begin
          dec_d = ext_view;                                        // RULE19
          st_d  = ST_RUN;                                          // RULE14
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // Phase counter and state.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      phase_q <= ifd_pkg::PHASE_RST;
      st_q    <= ST_RUN;
    end else begin
      phase_q <= phase_d;
      st_q    <= st_d;
    end
  end

  // Held first word and the decoded output.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      first_q <= '0;
      dec_q   <= '0;
    end else begin
      if (start_ext) begin
        first_q <= word_view;                                      // RULE1
      end
      dec_q <= dec_d;
    end
  end

  // Strobes reported one clock after the boundary that caused them.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      end_q   <= 1'b0;
      taken_q <= 1'b0;
      disp_q  <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      end_q   <= boundary;
      taken_q <= boundary;
      disp_q  <= issue;                                            // RULE12
      flush_q <= issue ? do_flush : flush_q;                       // RULE11
    end
  end

  // Outputs straight from flip-flops.
  assign PHASE      = phase_q;
  assign CYCLE_END  = end_q;
  assign WORD_TAKEN = taken_q;
  assign DISPATCH   = disp_q;
  assign FLUSHED    = flush_q;
  assign DECODED    = dec_q;

endmodule

`default_nettype wire

/* design/ifd_pkg.sv */
// ============================================================
// Shared constants and types of the instruction format decoder.
package ifd_pkg;

  // ============================================================
  // Word and field geometry.
  localparam int WORD_W     = 16;
  localparam int FILE_W     = 8;
  localparam int BITPOS_W   = 3;
  localparam int OFFSET_W   = 11;
  localparam int EXT_W      = 12;
  localparam int PHASES_DEF = 4;

  // Field positions inside a program word.
  localparam int TOP_HI     = 15;
  localparam int TOP_LO     = 12;
  localparam int DEST_POS   = 9;
  localparam int MEM_POS    = 8;
  localparam int BIT_HI     = 11;
  localparam int BIT_LO     = 9;
  localparam int QUICK_POS  = 8;
  localparam int PTR_HI     = 5;
  localparam int PTR_LO     = 4;
  localparam int MODE_HI    = 1;
  localparam int MODE_LO    = 0;
  localparam int SUB_HI     = 11;
  localparam int SUB_LO     = 8;
  localparam int CALL_HI    = 11;
  localparam int CALL_LO    = 9;

  // Top nibble codes that pick the instruction class.
  localparam logic [3:0] TOP_MISC   = 4'h0;
  localparam logic [3:0] TOP_BIT_LO = 4'h7;
  localparam logic [3:0] TOP_BIT_HI = 4'hb;
  localparam logic [3:0] TOP_JUMP   = 4'hd;
  localparam logic [3:0] TOP_LONG   = 4'he;
  localparam logic [3:0] TOP_EXT    = 4'hf;

  // Sub codes under TOP_LONG that make the three double-word forms, and SUB_NONE under TOP_MISC.
  localparam logic [2:0] SUB_CALL   = 3'h6;
  localparam logic [3:0] SUB_GOTO   = 4'hf;
  localparam logic [3:0] SUB_PTRLD  = 4'he;
  localparam logic [3:0] SUB_NONE   = 4'h0;

  // Reset values.
  localparam logic [1:0] PHASE_RST  = 2'h0;

  // Instruction classes.
  typedef enum logic [2:0] {
    CLS_BYTE    = 3'h0,
    CLS_BIT     = 3'h1,
    CLS_LITERAL = 3'h2,
    CLS_CONTROL = 3'h3,
    CLS_NOP     = 3'h4
  } ifd_class_t;

  // Table pointer update modes.
  typedef enum logic [1:0] {
    TBL_KEEP     = 2'h0,
    TBL_POST_INC = 2'h1,
    TBL_POST_DEC = 2'h2,
    TBL_PRE_INC  = 2'h3
  } ifd_tbl_t;

  // One decoded instruction as handed to the execute logic.
  typedef struct packed {
    ifd_class_t          cls;
    logic [7:0]          opcode;
    logic [FILE_W-1:0]   reg_addr;
    logic                result_to_file;
    logic                result_to_working;
    logic                access_ram;
    logic                bank_from_select;
    logic [BITPOS_W-1:0] bit_pos;
    logic [FILE_W-1:0]   bit_mask;
    logic [FILE_W-1:0]   literal_value;
    logic [1:0]          pointer_sel;
    logic [OFFSET_W-1:0] target_offset;
    logic                quick_return;
    ifd_tbl_t            table_mode;
    logic                two_word;
    logic [EXT_W-1:0]    ext_operand;
  } ifd_dec_t;

endpackage
